// ### src/adc_seq_pkg.sv
// Constants, types and helpers shared by the converter sequencing control.
// Assumes one 50 MHz system clock that also serves as the converter clock fc.
//
// What this block does
// - Repeat mode plus a start write begins converting the selected channel.
// - On completion store result, set end flag, raise done interrupt together.
// - Repeat mode starts the next conversion of the same channel automatically.
// - Writing mode 00 stops any running conversion at once.
// - An aborted conversion never reaches the result registers.
// - Software-start mode begins one conversion right after a start write.
// - Result is stored only after the selected conversion time has elapsed.
// - Reading the high result register clears the end-of-conversion flag.
// - A new start clears the end flag but keeps the old result.
// - Standby abandons the conversion and resets both control registers.
// - Standby discards earlier results; result registers are cleared.
// - After standby nothing restarts until software configures and starts again.
// - Standby disconnects the reference ladder so no reference current flows.
// - Each conversion yields a 10-bit unsigned code.
// - Mode 00 disabled, 01 software start, 11 repeat, 10 reserved.
// - Start bit clears itself once a conversion has begun.
// - Busy reads 1 during a conversion and clears on standby.
// - Time codes give 39 to 1248 clock periods; 001 and 111 reserved.

`default_nettype none

package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Register map: printed offsets are indices, bytes are four apart
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  IDX_CTRL_ONE  = 8'h0e;
  localparam logic [7:0]  IDX_CTRL_TWO  = 8'h0f;
  localparam logic [7:0]  IDX_RES_LOW   = 8'h20;
  localparam logic [7:0]  IDX_RES_HIGH  = 8'h21;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned START_BIT   = 7;
  localparam int unsigned MODE_HI     = 6;
  localparam int unsigned MODE_LO     = 5;
  localparam int unsigned IN_DIS_BIT  = 4;
  localparam int unsigned CHAN_HI     = 3;
  localparam int unsigned CHAN_LO     = 0;
  localparam int unsigned LADDER_BIT  = 5;
  localparam int unsigned TIME_HI     = 3;
  localparam int unsigned TIME_LO     = 1;
  localparam int unsigned RES_LO_HI   = 7;
  localparam int unsigned RES_LO_LO   = 6;
  localparam int unsigned EOC_BIT     = 5;
  localparam int unsigned BUSY_BIT    = 4;
  localparam int unsigned RESULT_W    = 10;
  localparam int unsigned CNT_W       = 11;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_off    = 2'b00,
    mode_soft   = 2'b01,
    mode_resv   = 2'b10,
    mode_repeat = 2'b11
  } op_mode_t;

  typedef enum logic {
    st_idle = 1'b0,
    st_conv = 1'b1
  } conv_state_t;

  localparam logic [3:0] CHAN_RST   = 4'h0;
  localparam logic [2:0] TIME_RST   = 3'h0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Conversion time, in periods of fc
  // ----------------------------------------------------------------
  localparam longint CLK_HZ    = 50_000_000;
  localparam longint FC_HZ     = 50_000_000;
  localparam longint PER_000   = 39;
  localparam longint PER_010   = 78;
  localparam longint PER_011   = 156;
  localparam longint PER_100   = 312;
  localparam longint PER_101   = 624;
  localparam longint PER_110   = 1248;

  // Reserved codes fall back to the longest time, the safe side for accuracy
  function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] code);
    longint per;
    unique case (code)
      3'h0:    per = PER_000;
      3'h2:    per = PER_010;
      3'h3:    per = PER_011;
      3'h4:    per = PER_100;
      3'h5:    per = PER_101;
      default: per = PER_110;
    endcase
    return CNT_W'(per * CLK_HZ / FC_HZ);
  endfunction

endpackage

`default_nettype wire

// ### src/conv_timer_if.sv
// Handshake between the sequencer and its conversion timer.
// Assumes both ends run on the same system clock.

`default_nettype none

interface conv_timer_if;
  logic       start;
  logic       abort;
  logic [2:0] time_code;
  logic       done;

  modport ctrl  (output start, output abort, output time_code, input done);
  modport timer (input start, input abort, input time_code, output done);
endinterface

`default_nettype wire

// ### src/conv_timer.sv
// Conversion time counter: loads on start, reports the last cycle as done.
// Assumes start and abort are single-cycle requests from the same clock.

`default_nettype none

module conv_timer
  import adc_seq_pkg::*;
(
  input wire logic      aclk,
  input wire logic      aresetn,
  conv_timer_if.timer   tmr
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // Done is combinational so the store lands exactly on the N-th edge
  assign tmr.done = (cnt_q == CNT_W'(1));

  always_comb begin
    cnt_d = cnt_q;
    if (tmr.abort) begin
      cnt_d = '0;
    end else if (tmr.start) begin
      cnt_d = conv_cycles(tmr.time_code);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // conv_timer

`default_nettype wire

// ### src/adc_seq_ctrl.sv
// Sequencing control of a 10-bit converter behind an AXI4-Lite register slave.
// Assumes standby_entry comes from the clock controller on aclk; the analog
// code is from outside the domain and is resynchronised before use.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.

`default_nettype none

module adc_seq_ctrl
  import adc_seq_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic [2:0]          arprot,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                standby_entry,
  input  wire logic [RESULT_W-1:0] adc_code,
  output logic                     adc_start,
  output logic [3:0]               adc_channel,
  output logic                     adc_input_disable,
  output logic                     adc_ladder_on,
  output logic                     conversion_done_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                aw_held_q,  aw_held_d;
  logic [ADDR_W-1:0]   awaddr_q,   awaddr_d;
  logic                w_held_q,   w_held_d;
  logic [7:0]          wdata_q,    wdata_d;
  logic                wstrb_q,    wstrb_d;
  logic                bvalid_q,   bvalid_d;
  logic [1:0]          bresp_q,    bresp_d;
  logic                rvalid_q,   rvalid_d;
  logic [31:0]         rdata_q,    rdata_d;
  logic [1:0]          rresp_q,    rresp_d;
  logic                start_q,    start_d;
  op_mode_t            mode_q,     mode_d;
  logic                in_dis_q,   in_dis_d;
  logic [3:0]          chan_q,     chan_d;
  logic                ladder_q,   ladder_d;
  logic [2:0]          time_q,     time_d;
  conv_state_t         state_q,    state_d;
  logic [RESULT_W-1:0] result_q,   result_d;
  logic                eoc_q,      eoc_d;
  logic                irq_q,      irq_d;
  logic                astart_q,   astart_d;
  logic [3:0]          cchan_q,    cchan_d;
  logic                lad_on_q,   lad_on_d;
  logic [RESULT_W-1:0] code_s1_q;
  logic [RESULT_W-1:0] code_s2_q;

  logic                wr_fire;
  logic                rd_fire;
  logic                rd_high;
  logic                begin_now;
  logic                busy;

  conv_timer_if tif ();

  conv_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tmr     (tif.timer)
  );

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  assign awready = !aw_held_q;
  assign wready  = !w_held_q;
  assign arready = !rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign rd_fire = arvalid && !rvalid_q;
  assign rd_high = rd_fire && (araddr == byte_addr(IDX_RES_HIGH));
  assign busy    = (state_q == st_conv);

  assign adc_start           = astart_q;
  assign adc_channel         = cchan_q;
  assign adc_input_disable   = in_dis_q;
  assign adc_ladder_on       = lad_on_q;
  assign conversion_done_irq = irq_q;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d  = awaddr_q;
    w_held_d  = w_held_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    start_d   = start_q;
    mode_d    = mode_q;
    in_dis_d  = in_dis_q;
    chan_d    = chan_q;
    ladder_d  = ladder_q;
    time_d    = time_q;
    state_d   = state_q;
    result_d  = result_q;
    eoc_d     = eoc_q;
    irq_d     = 1'b0;
    astart_d  = 1'b0;
    cchan_d   = cchan_q;
    begin_now = 1'b0;
    tif.abort = 1'b0;

    // Address and data are taken independently, in either order
    if (awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      awaddr_d  = awaddr;
    end
    if (wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      wdata_d  = wdata[7:0];
      wstrb_d  = wstrb[0];
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      if (awaddr_q == byte_addr(IDX_CTRL_ONE)) begin
        if (wstrb_q) begin
          start_d  = wdata_q[START_BIT];
          mode_d   = op_mode_t'(wdata_q[MODE_HI:MODE_LO]);
          in_dis_d = wdata_q[IN_DIS_BIT];
          chan_d   = wdata_q[CHAN_HI:CHAN_LO];
        end
      end else if (awaddr_q == byte_addr(IDX_CTRL_TWO)) begin
        if (wstrb_q) begin
          ladder_d = wdata_q[LADDER_BIT];
          time_d   = wdata_q[TIME_HI:TIME_LO];
        end
      end else if (awaddr_q != byte_addr(IDX_RES_LOW) &&
                   awaddr_q != byte_addr(IDX_RES_HIGH)) begin
        bresp_d = RESP_SLVERR;
      end
    end

    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      if (araddr == byte_addr(IDX_CTRL_ONE)) begin
        rdata_d[START_BIT]       = start_q;
        rdata_d[MODE_HI:MODE_LO] = mode_q;
        rdata_d[IN_DIS_BIT]      = in_dis_q;
        rdata_d[CHAN_HI:CHAN_LO] = chan_q;
      end else if (araddr == byte_addr(IDX_CTRL_TWO)) begin
        rdata_d[LADDER_BIT]      = ladder_q;
        rdata_d[TIME_HI:TIME_LO] = time_q;
      end else if (araddr == byte_addr(IDX_RES_LOW)) begin
        rdata_d[RES_LO_HI:RES_LO_LO] = result_q[1:0];
        rdata_d[EOC_BIT]             = eoc_q;
        rdata_d[BUSY_BIT]            = busy;
      end else if (araddr == byte_addr(IDX_RES_HIGH)) begin
        rdata_d[7:0] = result_q[RESULT_W-1:2];
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end

    // Clear before set, so a completion in the same cycle keeps the flag
    if (rd_high) begin
      eoc_d = 1'b0;
    end

    unique case (state_q)
      st_idle: begin
        // Reserved mode 10 and mode 00 never start
        if (start_q && (mode_q == mode_soft || mode_q == mode_repeat)) begin
          begin_now = 1'b1;
          eoc_d     = 1'b0;
        end
      end
      st_conv: begin
        if (mode_q == mode_off) begin
          tif.abort = 1'b1;
          state_d   = st_idle;
        end else if (tif.done) begin
          result_d = code_s2_q;
          eoc_d    = 1'b1;
          irq_d    = 1'b1;
          if (mode_q == mode_repeat) begin
            begin_now = 1'b1;
          end else begin
            state_d = st_idle;
          end
        end
      end
    endcase

    if (begin_now) begin
      state_d  = st_conv;
      start_d  = 1'b0;
      astart_d = 1'b1;
      cchan_d  = chan_q;
    end

    // Standby overrides everything; nothing resumes on return
    if (standby_entry) begin
      tif.abort = 1'b1;
      begin_now = 1'b0;
      state_d   = st_idle;
      start_d   = 1'b0;
      mode_d    = mode_off;
      in_dis_d  = 1'b0;
      chan_d    = CHAN_RST;
      ladder_d  = 1'b0;
      time_d    = TIME_RST;
      result_d  = '0;
      eoc_d     = 1'b0;
      irq_d     = 1'b0;
      astart_d  = 1'b0;
    end

    lad_on_d = !standby_entry && (ladder_d || state_d == st_conv);
  end

  assign tif.start     = begin_now;
  assign tif.time_code = time_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
      w_held_q  <= 1'b0;
      wdata_q   <= '0;
      wstrb_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
      start_q   <= 1'b0;
      mode_q    <= mode_off;
      in_dis_q  <= 1'b0;
      chan_q    <= CHAN_RST;
      ladder_q  <= 1'b0;
      time_q    <= TIME_RST;
      state_q   <= st_idle;
      result_q  <= '0;
      eoc_q     <= 1'b0;
      irq_q     <= 1'b0;
      astart_q  <= 1'b0;
      cchan_q   <= CHAN_RST;
      lad_on_q  <= 1'b0;
      code_s1_q <= '0;
      code_s2_q <= '0;
    end else begin
      aw_held_q <= aw_held_d;
      awaddr_q  <= awaddr_d;
      w_held_q  <= w_held_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      start_q   <= start_d;
      mode_q    <= mode_d;
      in_dis_q  <= in_dis_d;
      chan_q    <= chan_d;
      ladder_q  <= ladder_d;
      time_q    <= time_d;
      state_q   <= state_d;
      result_q  <= result_d;
      eoc_q     <= eoc_d;
      irq_q     <= irq_d;
      astart_q  <= astart_d;
      cchan_q   <= cchan_d;
      lad_on_q  <= lad_on_d;
      code_s1_q <= adc_code;
      code_s2_q <= code_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] elapsed_q;
  logic [CNT_W-1:0] expect_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elapsed_q <= '0;
      expect_q  <= '0;
    end else if (begin_now) begin
      elapsed_q <= CNT_W'(1);
      expect_q  <= conv_cycles(time_q);
    end else if (busy) begin
      elapsed_q <= elapsed_q + CNT_W'(1);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_repeat_start;
    !busy && start_q && mode_q == mode_repeat && !standby_entry |=> busy && adc_start;
  endproperty
  a_repeat_start: assert property (p_repeat_start) else $error("repeat start missed");

  property p_complete;
    busy && tif.done && mode_q != mode_off && !standby_entry
      |=> eoc_q && irq_q && result_q == $past(code_s2_q);
  endproperty
  a_complete: assert property (p_complete) else $error("completion not stored");

  property p_repeat_next;
    busy && tif.done && mode_q == mode_repeat && !standby_entry |=> busy ##0 adc_start;
  endproperty
  a_repeat_next: assert property (p_repeat_next) else $error("repeat did not rearm");

  property p_abort;
    busy && mode_q == mode_off && !standby_entry |=> !busy ##1 !irq_q;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not immediate");

  property p_no_store;
    busy && mode_q == mode_off && !standby_entry |=> $stable(result_q) && !irq_q;
  endproperty
  a_no_store: assert property (p_no_store) else $error("aborted value stored");

  property p_soft_start;
    !busy && start_q && mode_q == mode_soft && !standby_entry |=> busy && !start_q;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("software start missed");

  property p_time;
    busy && tif.done |-> elapsed_q == expect_q;
  endproperty
  a_time: assert property (p_time) else $error("conversion time wrong");

  property p_read_clear;
    rd_high && !(busy && tif.done) && !begin_now |=> !eoc_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");

  property p_restart_keep;
    !busy && begin_now && !standby_entry |=> !eoc_q && $stable(result_q);
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("restart lost result");

  property p_standby;
    standby_entry |=> !busy && !start_q && mode_q == mode_off && result_q == '0
      && !adc_ladder_on;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not applied");

  property p_irq_pulse;
    irq_q |=> !irq_q;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a pulse");

endmodule // adc_seq_ctrl

`default_nettype wire

// ### dv/analog_core_model.sv
// Behavioural analog core: returns a code per channel once its settle time has passed.
// Assumes adc_start is a one-cycle pulse on aclk and the channel is valid beside it.
`default_nettype none

module analog_core_model #(
  parameter int SETTLE = 2
) (
  input  wire logic       aclk,
  input  wire logic       adc_start,
  input  wire logic [3:0] adc_channel,
  output var  logic [9:0] adc_code
);
  timeunit 1ns;
  timeprecision 1ps;

  int         age  = 9999;
  logic [3:0] ch_q = 4'h0;

  initial adc_code = 10'h155;

  always @(posedge aclk) begin
    if (adc_start) begin
      age  <= 0;
      ch_q <= adc_channel;
    end else if (age < 9999) begin
      age <= age + 1;
    end
  end

  // Outside the valid window the line toggles, so a stale value never looks right
  always @(posedge aclk) begin
    adc_code <= (age >= SETTLE && age < 1300) ? 10'(ch_q * 67 + 13) : ~adc_code;
  end
endmodule // analog_core_model

`default_nettype wire

// ### dv/adc_sequencing_control_tb.sv
// Self-checking bench for the converter sequencing control over AXI4-Lite.
// Assumes the package and modules of src/ and the analog core model of dv/.
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module adc_sequencing_control_tb
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] A1  = 8'(IDX_CTRL_ONE * 4);
  localparam logic [7:0] A2  = 8'(IDX_CTRL_TWO * 4);
  localparam logic [7:0] ALO = 8'(IDX_RES_LOW * 4);
  localparam logic [7:0] AHI = 8'(IDX_RES_HIGH * 4);

  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, standby_entry = 1'b0, irq_q = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, adc_start, adc_input_disable;
  logic adc_ladder_on, conversion_done_irq;
  logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]         wdata  = 32'h0, rdata;
  logic [1:0]          bresp, rresp;
  logic [3:0]          adc_channel;
  logic [RESULT_W-1:0] adc_code;
  int fails = 0, cmp_count = 0, since = 0, gap = 0, irqs = 0;

  adc_seq_ctrl u_dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .standby_entry, .adc_code, .adc_start,
    .adc_channel, .adc_input_disable, .adc_ladder_on, .conversion_done_irq
  );
  analog_core_model #(.SETTLE(30)) u_core (.aclk, .adc_start, .adc_channel, .adc_code);

  initial begin
    forever #10 aclk = ~aclk;
  end

  // Gap counts cycles from the start pulse to the done pulse
  always @(posedge aclk) begin
    since <= adc_start ? 1 : since + 1;
    irq_q <= conversion_done_irq;
    if (conversion_done_irq) begin
      gap  <= since;
      irqs <= irqs + 1;
      `CHK(irq_q, 1'b0)
    end
  end

  function automatic int nper(input logic [2:0] c);
    case (c)
      3'h0: return 39;
      3'h2: return 78;
      3'h3: return 156;
      3'h4: return 312;
      3'h5: return 624;
      default: return 1248;
    endcase
  endfunction

  function automatic logic [9:0] ecode(input logic [3:0] ch);
    return 10'(ch * 67 + 13);
  endfunction

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] br;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        `CHK(br, er)
        // Let one edge pass so a following call never re-raises bready in this step
        @(posedge aclk);
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hd;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hd = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hd) begin
        rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    hang();
  endtask

  task automatic res(input logic [9:0] e, input logic eoc, input logic busy);
    logic [31:0] v;
    logic [1:0]  r;
    rd(ALO, v, r);
    `CHK(v, {24'h0, e[1:0], eoc, busy, 4'h0})
    rd(AHI, v, r);
    `CHK(v, {24'h0, e[9:2]})
  endtask

  task automatic wirq(input int k);
    for (int i = 0; i < 3000; i++) begin
      @(posedge aclk);
      if (irqs >= k) return;
    end
    hang();
  endtask

  task automatic hang();
    fails++;
    tally_and_finish();
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    logic [3:0]  ch, c0;
    int          k0;
    void'($urandom(51339));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A1, v, r);
    `CHK(v, 32'h0)
    rd(8'h90, v, r);
    `CHK(r, RESP_SLVERR)
    wr(8'h90, 8'hff, RESP_SLVERR);
    $display("test map done");
    for (int tc = 0; tc < 7; tc++) begin
      if (tc == 1) continue;
      ch = 4'($urandom % 6);
      wr(A2, {2'b00, 1'b1, 1'b0, 3'(tc), 1'b0}, RESP_OKAY);
      wr(A1, {4'ha, ch}, RESP_OKAY);
      rd(A1, v, r);
      `CHK(v[7:0], {4'h2, ch})
      rd(ALO, v, r);
      `CHK(v[4], 1'b1)
      wirq(irqs + 1);
      `CHK(gap, nper(3'(tc)))
      res(ecode(ch), 1'b1, 1'b0);
      rd(ALO, v, r);
      `CHK(v[5], 1'b0)
    end
    $display("test soft start done");
    c0 = ch;
    wr(A1, {4'ha, c0}, RESP_OKAY);
    wirq(irqs + 1);
    ch = 4'(($urandom % 5 + c0 + 1) % 6);
    wr(A1, {4'ha, ch}, RESP_OKAY);
    res(ecode(c0), 1'b0, 1'b1);
    wirq(irqs + 1);
    res(ecode(ch), 1'b1, 1'b0);
    $display("test retain done");
    wr(A2, 8'h00, RESP_OKAY);
    wr(A1, {4'he, ch}, RESP_OKAY);
    wirq(irqs + 1);
    repeat (2) begin
      wirq(irqs + 1);
      `CHK(gap, 39)
    end
    `CHK(adc_channel, ch)
    repeat (10) @(posedge aclk);
    wr(A1, 8'h00, RESP_OKAY);
    k0 = irqs;
    repeat (100) @(posedge aclk);
    `CHK(irqs, k0)
    res(ecode(ch), 1'b1, 1'b0);
    for (int m = 0; m < 2; m++) begin
      k0 = irqs;
      wr(A1, (m == 0) ? 8'h90 : 8'hc0, RESP_OKAY);
      repeat (60) @(posedge aclk);
      `CHK(irqs, k0)
      `CHK(adc_input_disable, 1'(m == 0))
    end
    $display("test repeat done");
    wr(A2, 8'h20, RESP_OKAY);
    wr(A1, {4'ha, ch}, RESP_OKAY);
    repeat (5) @(posedge aclk);
    `CHK(adc_ladder_on, 1'b1)
    k0 = irqs;
    standby_entry <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    `CHK(adc_ladder_on, 1'b0)
    @(posedge aclk);
    standby_entry <= 1'b0;
    repeat (100) @(posedge aclk);
    `CHK(irqs, k0)
    rd(A1, v, r);
    `CHK(v, 32'h0)
    rd(A2, v, r);
    `CHK(v, 32'h0)
    res(10'h0, 1'b0, 1'b0);
    $display("test standby done");
    tally_and_finish();
  end
endmodule // adc_sequencing_control_tb

`default_nettype wire
